// ### cmc_pkg.sv
package cmc_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] CMC_OFF_CON0_1 = 8'h00;
  localparam logic [7:0] CMC_OFF_CON1_1 = 8'h04;
  localparam logic [7:0] CMC_OFF_CON0_2 = 8'h08;
  localparam logic [7:0] CMC_OFF_CON1_2 = 8'h0c;
  localparam logic [7:0] CMC_OFF_MIRROR = 8'h10;
  localparam logic [7:0] CMC_OFF_FLAGS = 8'h14;
  localparam logic [7:0] CMC_OFF_PINCFG = 8'h18;

  // ==========================================================
  // control_reg_zero fields
  localparam int CMC_B_ON = 7;
  localparam int CMC_B_OUT = 6;
  localparam int CMC_B_OE = 5;
  localparam int CMC_B_POL = 4;
  localparam int CMC_B_SP = 2;
  localparam int CMC_B_HYS = 1;
  localparam int CMC_B_SYNC = 0;
  // control_reg_one fields
  localparam int CMC_B_INTP = 7;
  localparam int CMC_B_INTN = 6;
  localparam int CMC_B_PCH = 4;
  localparam int CMC_B_NCH = 0;
  // pin config register fields
  localparam int CMC_B_DIR = 0;
  localparam int CMC_B_LAT = 2;

  localparam logic [7:0] CMC_CON0_RST = 8'h04;
  localparam logic [7:0] CMC_CON1_RST = 8'h00;
  localparam logic [7:0] CMC_PINCFG_RST = 8'h03;
  localparam logic [7:0] CMC_CON0_WMASK = 8'hb7;
  localparam logic [7:0] CMC_CON1_WMASK = 8'hf3;

  localparam logic [1:0] CMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMC_RESP_SLVERR = 2'h2;

  // Plus input select codes
  localparam logic [1:0] CMC_PCH_OWN = 2'h0;
  localparam logic [1:0] CMC_PCH_LADDER = 2'h1;
  localparam logic [1:0] CMC_PCH_FIXED = 2'h2;
  localparam logic [1:0] CMC_PCH_ALT = 2'h3;

  // ==========================================================
  // Analog switch controls for one comparator
  typedef struct packed {
    logic enable;
    logic fast_mode;
    logic hysteresis;
    logic [3:0] plus_sel;
    logic [3:0] minus_sel;
  } cmc_analog_s;

  typedef enum logic [2:0] {
    CMC_W_IDLE = 3'b001,
    CMC_W_RESP = 3'b010,
    CMC_W_HOLD = 3'b100
  } cmc_wstate_e;

  function automatic logic [3:0] cmc_onehot(input logic [1:0] code);
    cmc_onehot = 4'h1 << code;
  endfunction

endpackage

// ### cmc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_sync
  import cmc_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic d_async, // Asynchronous level
  output logic q // Synchronised level
);

  logic stage1;

  // ==========================================================
  // Two-flop synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1 <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      stage1 <= d_async;
      q <= stage1;
    end
  end

endmodule
`default_nettype wire

// ### cmc_unit.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_unit
  import cmc_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic [7:0] con0, // control_reg_zero
  input wire logic [7:0] con1, // control_reg_one
  input wire logic raw_cmp, // Analog comparator output
  input wire logic tmr_clk_en, // Gate timer clock edge pulse
  input wire logic tmr_clk_lvl, // Gate timer clock level
  output logic result, // Registered final result
  output logic sync_out, // Synchronised external result
  output logic edge_event, // Qualified edge pulse
  output cmc_analog_s analog // Analog switch controls
);

  logic cmp_s;
  logic final_res;
  logic prev_res;
  logic prev_tclk;
  logic enabled;

  assign enabled = con0[CMC_B_ON];

  cmc_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d_async(raw_cmp),
    .q(cmp_s)
  );

  // Gating and polarity
  assign final_res = enabled & (cmp_s ^ con0[CMC_B_POL]);

  // ==========================================================
  // Result register and edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      result <= 1'b0;
      prev_res <= 1'b0;
    end
    else
    begin
      result <= final_res;
      prev_res <= final_res;
    end
  end

  // Edges on final result, so polarity/enable toggles also count
  assign edge_event = (final_res & ~prev_res & con1[CMC_B_INTP]) |
    (~final_res & prev_res & con1[CMC_B_INTN]);

  // ==========================================================
  // Capture on falling edge of (prescaled) timer clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_tclk <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      prev_tclk <= tmr_clk_lvl;
      if (tmr_clk_en && prev_tclk && !tmr_clk_lvl)
      begin
        sync_out <= final_res;
      end
    end
  end

  // ==========================================================
  // Analog controls, all switches but fast_mode open when off
  always_comb
  begin
    analog.enable = enabled;
    analog.fast_mode = con0[CMC_B_SP];
    analog.hysteresis = enabled & con0[CMC_B_HYS];
    analog.plus_sel = enabled ?
      cmc_onehot(con1[CMC_B_PCH +: 2]) : 4'h0;
    analog.minus_sel = enabled ?
      cmc_onehot(con1[CMC_B_NCH +: 2]) : 4'h0;
  end

endmodule
`default_nettype wire

// ### cmc_top.sv
// Behaviour
// - Comparator runs only while comparator_on; off means minimum current.
// - Disabled comparator outputs constant zero; timer-synced external path keeps last capture until next timer falling edge.
// - Result readable in compare_result_bit and mirrored_result_bit.
// - Result drives pin only with result_pin_enable, pin output, comparator_on; pin output alone drives the port latch.
// - result_pin_enable overrides port latch regardless of comparator_on.
// - Internal result registered each cycle; external path reuses it unless timer-synced.
// - Result is plus above minus, complemented by result_invert.
// - speed_power_select resets to one; zero selects low power.
// - hysteresis_on enables input hysteresis.
// - Result offered to gate timer as gate source.
// - timer_sync_select captures result on timer clock falling edge.
// - Capture uses the prescaled timer clock.
// - Rise and fall detectors set compare_edge_flag when enabled.
// - Software clears flag; simultaneous new edge leaves it set.
// - Edge detection uses final gated, polarity-adjusted result.
// - plus_input_select picks one of four plus-input sources.
// - Codes: own pin, ladder, fixed reference, shared pin or ground.
// - minus_input_select picks one of four minus pins.
// - Minus codes 0..3 select shared minus pins zero to three.
// - Disabled comparator disconnects all input multiplexers.
// - Both results go to the PWM shutdown logic.
`timescale 1ns/100ps
`default_nettype none
module cmc_top
  import cmc_pkg::*;
(
  input wire logic aclk, // Clock, 25 MHz
  input wire logic aresetn, // Sync reset, low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [1:0] raw_cmp, // Analog comparator outputs
  input wire logic tmr_clk_en, // Gate timer prescaled clock pulse
  input wire logic tmr_clk_lvl, // Gate timer prescaled clock level
  output logic [1:0] gate_timer_src, // Result to gate timer
  output logic [1:0] pwm_shutdown_src, // Result to PWM shutdown
  output logic [1:0] cmp_pin_o, // Result pin data
  output logic [1:0] cmp_pin_oe, // Result pin output enable
  output logic [1:0] compare_edge_flag, // Sticky edge flags
  output cmc_analog_s [1:0] analog_ctl // Analog switch controls
);

  logic [7:0] con0 [2];
  logic [7:0] con1 [2];
  logic [7:0] pincfg;
  logic [1:0] result;
  logic [1:0] sync_out;
  logic [1:0] edge_event;
  logic [1:0] ext_res;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic do_write;
  logic [1:0] flag_clr;
  logic [31:0] next_rdata;
  logic next_rerr;
  cmc_wstate_e wstate;

  // ==========================================================
  // Comparator units
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_unit
      cmc_unit u_unit (
        .aclk(aclk),
        .aresetn(aresetn),
        .con0(con0[gi]),
        .con1(con1[gi]),
        .raw_cmp(raw_cmp[gi]),
        .tmr_clk_en(tmr_clk_en),
        .tmr_clk_lvl(tmr_clk_lvl),
        .result(result[gi]),
        .sync_out(sync_out[gi]),
        .edge_event(edge_event[gi]),
        .analog(analog_ctl[gi])
      );
      // External path: registered result unless sync selected
      assign ext_res[gi] = con0[gi][CMC_B_SYNC] ?
        sync_out[gi] : result[gi];
      assign gate_timer_src[gi] = ext_res[gi];
      assign pwm_shutdown_src[gi] = result[gi];
      // Override port latch; comparator_on not part of override
      assign cmp_pin_o[gi] = con0[gi][CMC_B_OE] ?
        ext_res[gi] : pincfg[CMC_B_LAT + gi];
      assign cmp_pin_oe[gi] = ~pincfg[CMC_B_DIR + gi] &
        (~con0[gi][CMC_B_OE] | con0[gi][CMC_B_ON]);
    end
  endgenerate

  // ==========================================================
  // AXI write channel
  assign s_axi_awready = (wstate == CMC_W_IDLE) && !aw_held;
  assign s_axi_wready = (wstate == CMC_W_IDLE) && !w_held;
  assign do_write = (wstate == CMC_W_IDLE) &&
    (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Effective address/data for the write being performed
  logic [7:0] wa;
  logic [7:0] wd;
  logic wb0;
  assign wa = aw_held ? aw_addr : s_axi_awaddr;
  assign wd = w_held ? w_data[7:0] : s_axi_wdata[7:0];
  assign wb0 = w_held ? w_strb[0] : s_axi_wstrb[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wstate <= CMC_W_IDLE;
      s_axi_bresp <= CMC_RESP_OKAY;
    end
    else
    begin
      case (wstate)
        CMC_W_IDLE:
        begin
          if (do_write)
          begin
            wstate <= CMC_W_RESP;
            s_axi_bresp <= (wa[1:0] != 2'h0 || wa > CMC_OFF_PINCFG) ?
              CMC_RESP_SLVERR : CMC_RESP_OKAY;
          end
        end
        CMC_W_RESP:
        begin
          if (s_axi_bready)
          begin
            wstate <= CMC_W_IDLE;
          end
        end
        default:
        begin
          wstate <= CMC_W_IDLE;
        end
      endcase
    end
  end
  assign s_axi_bvalid = (wstate == CMC_W_RESP);

  // ==========================================================
  // Registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      con0[0] <= CMC_CON0_RST;
      con0[1] <= CMC_CON0_RST;
      con1[0] <= CMC_CON1_RST;
      con1[1] <= CMC_CON1_RST;
      pincfg <= CMC_PINCFG_RST;
    end
    else if (do_write && wb0)
    begin
      case (wa)
        CMC_OFF_CON0_1: con0[0] <= wd & CMC_CON0_WMASK;
        CMC_OFF_CON1_1: con1[0] <= wd & CMC_CON1_WMASK;
        CMC_OFF_CON0_2: con0[1] <= wd & CMC_CON0_WMASK;
        CMC_OFF_CON1_2: con1[1] <= wd & CMC_CON1_WMASK;
        CMC_OFF_PINCFG: pincfg <= wd;
        default: pincfg <= pincfg;
      endcase
    end
  end

  // Write-one-to-clear flags; a new edge wins
  assign flag_clr = (do_write && wb0 && wa == CMC_OFF_FLAGS) ?
    wd[1:0] : 2'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      compare_edge_flag <= 2'h0;
    end
    else
    begin
      compare_edge_flag <= (compare_edge_flag & ~flag_clr) |
        edge_event;
    end
  end

  // ==========================================================
  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    case (s_axi_araddr)
      CMC_OFF_CON0_1:
        next_rdata[7:0] = con0[0] | 8'(result[0]) << CMC_B_OUT;
      CMC_OFF_CON1_1: next_rdata[7:0] = con1[0];
      CMC_OFF_CON0_2:
        next_rdata[7:0] = con0[1] | 8'(result[1]) << CMC_B_OUT;
      CMC_OFF_CON1_2: next_rdata[7:0] = con1[1];
      CMC_OFF_MIRROR: next_rdata[1:0] = result;
      CMC_OFF_FLAGS: next_rdata[1:0] = compare_edge_flag;
      CMC_OFF_PINCFG: next_rdata[7:0] = pincfg;
      default: next_rerr = 1'b1;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CMC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rerr ? CMC_RESP_SLVERR : CMC_RESP_OKAY;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### cmc_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_top_sva
  import cmc_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] pwm_shutdown_src, // Registered result
  input wire logic [1:0] compare_edge_flag, // Edge flags
  input wire cmc_analog_s [1:0] analog_ctl // Switch controls
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Result gating and input switches
  a_off_zero_one: assert property (
    !analog_ctl[0].enable && !$past(analog_ctl[0].enable)
    |-> !pwm_shutdown_src[0]) else $error("Result high while off");
  a_off_zero_two: assert property (
    !analog_ctl[1].enable && !$past(analog_ctl[1].enable)
    |-> !pwm_shutdown_src[1]) else $error("Result two high while off");
  a_off_mux_open: assert property (
    !analog_ctl[1].enable |-> analog_ctl[1].plus_sel == 4'h0
    && analog_ctl[1].minus_sel == 4'h0 && !analog_ctl[1].hysteresis)
    else $error("Switch closed while off");
  a_on_one_source: assert property (
    analog_ctl[0].enable |-> $onehot(analog_ctl[0].plus_sel)
    && $onehot(analog_ctl[0].minus_sel)) else $error("Bad input select");

  // ==========================================================
  // Edge flag
  a_flag_on_edge: assert property (
    $rose(compare_edge_flag[0]) |-> $changed(pwm_shutdown_src[0]))
    else $error("Flag set without result edge");
  a_flag_clear_write: assert property (
    $fell(compare_edge_flag[0]) |-> $rose(s_axi_bvalid)
    && $past(s_axi_awaddr) == CMC_OFF_FLAGS && $past(s_axi_wdata[0]))
    else $error("Flag cleared without write");

  // ==========================================================
  // Register read port
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read not answered next cycle");
  a_read_one_busy: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && !s_axi_arready
    && $stable(s_axi_rdata)) else $error("Read answer not held");
endmodule

bind cmc_top cmc_top_sva u_sva (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_wdata, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pwm_shutdown_src,
  .compare_edge_flag, .analog_ctl);
`default_nettype wire

// ### cmc_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module cmc_analog_model
  import cmc_pkg::*;
(
  input wire logic aclk, // Clock for idle pattern
  input wire cmc_analog_s [1:0] analog_ctl, // Switch controls
  input wire logic [71:0] volts, // Levels, byte per source
  output logic [1:0] raw_cmp // Comparator outputs
);
  logic idle_tog = 1'b0;
  logic [7:0] vp;
  logic [7:0] vm;

  always @(posedge aclk)
    idle_tog <= !idle_tog;

  // ==========================================================
  // Source selection and comparison
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      vp = 8'h00;
      vm = 8'h00;
      for (int k = 0; k < 4; k++)
      begin
        if (analog_ctl[i].plus_sel[k])
          vp = (i == 1 && k == 3) ? 8'h00
            : volts[8*((i == 1 && k == 0) ? 4 : k) +: 8];
        if (analog_ctl[i].minus_sel[k])
          vm = volts[8*(5+k) +: 8];
      end
      // Open inputs leave the output wandering
      raw_cmp[i] = analog_ctl[i].enable ? vp > vm : idle_tog ^ i[0];
    end
  end
endmodule
`default_nettype wire

// ### comparator_control_logic_tb.sv
`timescale 1ns/100ps
`default_nettype none
module comparator_control_logic_tb
  import cmc_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic tmr_clk_en = 1'b0, tmr_clk_lvl = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, raw_cmp, gate_timer_src;
  logic [1:0] pwm_shutdown_src, cmp_pin_o, cmp_pin_oe, compare_edge_flag;
  logic [31:0] s_axi_rdata;
  cmc_analog_s [1:0] analog_ctl;
  logic [71:0] volts = 72'hdc_a0_78_50_64_c8_32_96_64;
  // Rows: control zero, control one, expected result
  logic [19:0] rows [9] = '{20'h84001, 20'h94000, 20'h84111, 20'h84220,
    20'h94221, 20'h84330, 20'h84301, 20'h04000, 20'h14000};
  logic [19:0] r;
  logic [7:0] sel;
  int fail_count = 0, checks_done = 0;

  cmc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .raw_cmp, .tmr_clk_en,
    .tmr_clk_lvl, .gate_timer_src, .pwm_shutdown_src, .cmp_pin_o,
    .cmp_pin_oe, .compare_edge_flag, .analog_ctl);
  cmc_analog_model u_model (.aclk, .analog_ctl, .volts, .raw_cmp);

  initial
    forever #20 aclk = ~aclk;

  // ==========================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] re = CMC_RESP_OKAY);
    logic ta, tw, tb;
    logic [1:0] rs;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      if (tb)
        break;
    end
    s_axi_bready <= 1'b0;
    chk(32'(rs), 32'(re));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] re = CMC_RESP_OKAY);
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(negedge aclk);
    while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do
      @(negedge aclk);
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(d, e);
    chk(32'(rs), 32'(re));
  endtask

  task automatic tick(input logic l);
    @(posedge aclk);
    tmr_clk_lvl <= l;
    tmr_clk_en <= 1'b1;
    @(posedge aclk);
    tmr_clk_en <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CMC_OFF_CON0_1, 32'h04);
    rd(CMC_OFF_PINCFG, 32'h03);
    rd(8'h1c, 32'h0, CMC_RESP_SLVERR);
    wr(8'h1c, 8'hff, CMC_RESP_SLVERR);
    wr(CMC_OFF_CON0_1, 8'h4c);
    rd(CMC_OFF_CON0_1, 32'h04);
    foreach (rows[n])
    begin
      r = rows[n];
      wr(CMC_OFF_CON1_1, r[11:4]);
      wr(CMC_OFF_CON0_1, r[19:12]);
      repeat (4) @(posedge aclk);
      rd(CMC_OFF_MIRROR, 32'(r[0]));
      rd(CMC_OFF_CON0_1, 32'(r[19:12] | {1'b0, r[0], 6'h0}));
      sel = r[19] ? {4'h1 << r[9:8], 4'h1 << r[5:4]} : 8'h00;
      @(negedge aclk);
      chk(32'({analog_ctl[0].plus_sel, analog_ctl[0].minus_sel}), 32'(sel));
      chk(32'(pwm_shutdown_src[0]), 32'(r[0]));
    end
    chk(32'(compare_edge_flag), 32'h0);
    wr(CMC_OFF_CON1_1, 8'h80);
    wr(CMC_OFF_CON0_1, 8'h84);
    // Switch-on edge may trail the write by the synchroniser depth
    repeat (3) @(negedge aclk);
    chk(32'(compare_edge_flag), 32'h1);
    rd(CMC_OFF_FLAGS, 32'h1);
    wr(CMC_OFF_FLAGS, 8'h01);
    wr(CMC_OFF_CON0_1, 8'h94);
    @(negedge aclk);
    chk(32'(compare_edge_flag), 32'h0);
    wr(CMC_OFF_CON1_1, 8'h40);
    wr(CMC_OFF_CON0_1, 8'h84);
    @(negedge aclk);
    chk(32'(compare_edge_flag), 32'h0);
    wr(CMC_OFF_CON0_1, 8'h94);
    @(negedge aclk);
    chk(32'(compare_edge_flag), 32'h1);
    wr(CMC_OFF_FLAGS, 8'h01);
    wr(CMC_OFF_CON0_1, 8'h84);
    // Falling edge lands on the clearing write
    @(posedge aclk);
    volts[7:0] <= 8'h32;
    @(posedge aclk);
    wr(CMC_OFF_FLAGS, 8'h01);
    @(negedge aclk);
    chk(32'(compare_edge_flag[0]), 32'h1);
    // Timer capture, pin 0 as output
    wr(CMC_OFF_PINCFG, 8'h02);
    volts[7:0] <= 8'h64;
    wr(CMC_OFF_CON0_1, 8'ha5);
    tick(1'b1);
    tick(1'b0);
    repeat (2) @(negedge aclk);
    chk(32'({gate_timer_src[0], cmp_pin_o[0], cmp_pin_oe[0]}), 32'h7);
    volts[7:0] <= 8'h32;
    repeat (5) @(negedge aclk);
    chk(32'({gate_timer_src[0], cmp_pin_o[0], pwm_shutdown_src[0]}), 32'h6);
    @(posedge aclk);
    tmr_clk_lvl <= 1'b1;
    @(posedge aclk);
    tmr_clk_lvl <= 1'b0;
    tick(1'b1);
    repeat (3) @(negedge aclk);
    chk(32'(gate_timer_src[0]), 32'h1);
    tick(1'b0);
    repeat (2) @(negedge aclk);
    chk(32'(gate_timer_src[0]), 32'h0);
    wr(CMC_OFF_CON0_1, 8'ha4);
    volts[7:0] <= 8'h64;
    repeat (5) @(negedge aclk);
    chk(32'({gate_timer_src[0], cmp_pin_o[0], pwm_shutdown_src[0]}), 32'h7);
    wr(CMC_OFF_PINCFG, 8'h06);
    wr(CMC_OFF_CON0_1, 8'h24);
    @(negedge aclk);
    chk(32'({cmp_pin_oe[0], cmp_pin_o[0]}), 32'h0);
    wr(CMC_OFF_CON0_1, 8'h04);
    @(negedge aclk);
    chk(32'({cmp_pin_oe[0], cmp_pin_o[0]}), 32'h3);
    wr(CMC_OFF_CON0_1, 8'h82);
    @(negedge aclk);
    chk(32'({analog_ctl[0].enable, analog_ctl[0].fast_mode,
      analog_ctl[0].hysteresis}), 32'h5);
    wr(CMC_OFF_CON1_2, 8'h30);
    wr(CMC_OFF_CON0_2, 8'h94);
    repeat (4) @(posedge aclk);
    rd(CMC_OFF_MIRROR, 32'h3);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CMC_OFF_FLAGS, 32'h0);
    rd(CMC_OFF_CON0_1, 32'h04);
    stop_test();
  end

  initial
  begin
    #800000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
